// ==== logic/sld_consts.svh ====
// Constants for the serial-in latched driver
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH
`define SLD_STAGES      8
`define SLD_FIFO_DEPTH  32
`define SLD_FIFO_AW     5
`define SLD_OUT_OFF     8'hff
`define SLD_RESET_VAL   8'h00
`endif

// ==== logic/sld_pkg.sv ====
// Types for the serial-in latched driver
package sld_pkg;
    typedef logic [7:0] sld_word_t;
endpackage

// ==== logic/sld_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
`include "sld_consts.svh"
module sld_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SLD_FIFO_DEPTH,
    parameter int AW    = `SLD_FIFO_AW
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Handshake and pointer update
    always_comb begin
        in_ready  = (cnt_q != (AW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d      = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d     = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        out_data  = mem[rd_q];
    end

    // Pointer registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end
endmodule

// ==== logic/sld_driver.sv ====
// Eight-stage serial-in shift register with latches and blanked outputs
`timescale 1ns/1ns
`include "sld_consts.svh"
module sld_driver (
    input  wire logic           clk,
    input  wire logic           resetn,
    input  wire logic           ser_in,
    input  wire logic           shift_clk,
    input  wire logic           load,
    input  wire logic           blank,
    output sld_pkg::sld_word_t  drive_out,
    output logic                cascade_out,
    output sld_pkg::sld_word_t  word_data,
    output logic                word_valid,
    input  wire logic           word_ready
);
    // Three-stage synchronisers for pins
    logic [2:0]         sclk_s_q, din_s_q, ld_s_q, bl_s_q;
    logic [2:0]         sclk_s_d, din_s_d, ld_s_d, bl_s_d;
    logic               sclk_q, din_q, ld_q, bl_q;
    logic               sclk_d, din_d, ld_d, bl_d;
    sld_pkg::sld_word_t sr_q, sr_d, lat_q, lat_d, out_q, out_d;
    logic [2:0]         bits_q, bits_d;
    logic               rise, push_d, push_q, fifo_in_ready;

    // Level moves only when stages two and three agree
    function automatic logic agreed(input logic [2:0] s, input logic cur);
        agreed = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    // Synchroniser stages take in the raw pin levels
    always_comb begin
        sclk_s_d = {sclk_s_q[1:0], shift_clk};
        din_s_d  = {din_s_q[1:0], ser_in};
        ld_s_d   = {ld_s_q[1:0], load};
        bl_s_d   = {bl_s_q[1:0], blank};
    end

    // Filtered levels update once stages two and three agree
    always_comb begin
        sclk_d = agreed(sclk_s_q, sclk_q);
        din_d  = agreed(din_s_q, din_q);
        ld_d   = agreed(ld_s_q, ld_q);
        bl_d   = agreed(bl_s_q, bl_q);
    end

    // Synchroniser and filtered level registers; blanking starts on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_s_q <= '0;
            din_s_q  <= '0;
            ld_s_q   <= '0;
            bl_s_q   <= 3'h7;
            sclk_q   <= 1'b0;
            din_q    <= 1'b0;
            ld_q     <= 1'b0;
            bl_q     <= 1'b1;
        end else begin
            sclk_s_q <= sclk_s_d;
            din_s_q  <= din_s_d;
            ld_s_q   <= ld_s_d;
            bl_s_q   <= bl_s_d;
            sclk_q   <= sclk_d;
            din_q    <= din_d;
            ld_q     <= ld_d;
            bl_q     <= bl_d;
        end
    end

    // Data is sampled with the clock it arrives with; host holds it stable
    assign rise = sclk_d && !sclk_q;

    // Shift register and bit counter; a full buffer refuses the edge
    always_comb begin
        sr_d   = sr_q;
        bits_d = bits_q;
        push_d = 1'b0;
        if (rise && fifo_in_ready) begin
            sr_d   = {sr_q[6:0], din_d};
            bits_d = 3'(bits_q + 1'b1);
            push_d = (bits_q == 3'h7);
        end
    end

    // Shift register, bit counter and word strobe registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sr_q   <= `SLD_RESET_VAL;
            bits_q <= '0;
            push_q <= 1'b0;
        end else begin
            sr_q   <= sr_d;
            bits_q <= bits_d;
            push_q <= push_d;
        end
    end

    // Latches follow the register while load is high, else hold
    always_comb begin
        lat_d = ld_q ? sr_q : lat_q;
    end

    // Latch registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lat_q <= `SLD_RESET_VAL;
        end else begin
            lat_q <= lat_d;
        end
    end

    // Output stage; blanking forces every output off
    always_comb begin
        out_d = bl_q ? `SLD_OUT_OFF : lat_q;
    end

    // Output registers; outputs come up off
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_q <= `SLD_OUT_OFF;
        end else begin
            out_q <= out_d;
        end
    end

    // Registered outputs
    assign drive_out   = out_q;
    assign cascade_out = sr_q[7];

    // Completed bytes are buffered for observers; full FIFO stalls shifting
    sld_fifo #(.WIDTH(`SLD_STAGES)) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (sr_q),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .out_data  (word_data),
        .out_valid (word_valid),
        .out_ready (word_ready)
    );

    // Accepted shift edge
    sequence s_rise;
        rise && fifo_in_ready;
    endsequence

    AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!resetn)
        s_rise |=> sr_q[0] == $past(din_d)) else $error("serial bit not captured");
    AST_SHIFT_MOVE: assert property (@(posedge clk) disable iff (!resetn)
        s_rise |=> sr_q[7:1] == $past(sr_q[6:0])) else $error("stages did not move");
    AST_HOLD_SR: assert property (@(posedge clk) disable iff (!resetn)
        !(rise && fifo_in_ready) |=> $stable(sr_q)) else $error("register moved without edge");
    AST_LATCH_FOLLOW: assert property (@(posedge clk) disable iff (!resetn)
        ld_q |=> lat_q == $past(sr_q)) else $error("latch not transparent");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        !ld_q |=> $stable(lat_q)) else $error("latch changed while load low");
    AST_BLANK: assert property (@(posedge clk) disable iff (!resetn)
        bl_q |=> drive_out == `SLD_OUT_OFF) else $error("outputs not off");
    AST_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
        !bl_q |=> drive_out == $past(lat_q)) else $error("outputs not from latches");
    AST_CASCADE: assert property (@(posedge clk) disable iff (!resetn)
        s_rise |=> cascade_out == $past(sr_q[6])) else $error("cascade wrong");

    // Shift clock pin change reaching the filtered level
    sequence s_sclk_arrives;
        (!sclk_q && sclk_s_q == 3'h3) ##1 (sclk_s_q == 3'h7);
    endsequence

    // Shift edge that lands while the word buffer is full
    sequence s_full_refuse;
        rise && !fifo_in_ready;
    endsequence

    // Eighth accepted edge of a word
    sequence s_byte_done;
        rise && fifo_in_ready && (bits_q == 3'h7);
    endsequence

    // Load pin rise working through the synchroniser
    sequence s_load_arrives;
        (ld_s_q == 3'h3) ##1 (ld_s_q == 3'h7);
    endsequence

    // Load pin fall working through the synchroniser
    sequence s_load_leaves;
        (ld_s_q == 3'h4) ##1 (ld_s_q == 3'h0);
    endsequence

    // Load high with outputs shown for two cycles
    sequence s_load_through;
        (ld_q && !bl_q) ##1 !bl_q;
    endsequence

    // Blank pin rise working through the synchroniser
    sequence s_blank_arrives;
        (bl_s_q == 3'h3) ##1 (bl_s_q == 3'h7);
    endsequence

    // Blank pin fall working through the synchroniser
    sequence s_blank_leaves;
        (bl_s_q == 3'h4) ##1 (bl_s_q == 3'h0);
    endsequence

    // Pin filtering, refused edges and word strobes
    AST_SCLK_FILTER: assert property (@(posedge clk) disable iff (!resetn)
        s_sclk_arrives |-> rise) else $error("shift edge not seen");
    AST_REFUSE_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        s_full_refuse |=> $stable(sr_q) && $stable(bits_q)) else $error("refused edge shifted");
    AST_BYTE_PUSH: assert property (@(posedge clk) disable iff (!resetn)
        s_byte_done |=> push_q ##1 !push_q) else $error("word strobe wrong");
    AST_PUSH_ALIGN: assert property (@(posedge clk) disable iff (!resetn)
        push_q |-> bits_q == 3'h0) else $error("word strobe off count");

    // Latch and output paths from the pins
    AST_LOAD_LAG: assert property (@(posedge clk) disable iff (!resetn)
        s_load_arrives |=> ld_q ##1 lat_q == $past(sr_q)) else $error("load pin not followed");
    AST_LOAD_DROP: assert property (@(posedge clk) disable iff (!resetn)
        s_load_leaves |=> !ld_q ##1 $stable(lat_q)) else $error("latch moved after load fell");
    AST_LOAD_THROUGH: assert property (@(posedge clk) disable iff (!resetn)
        s_load_through |=> drive_out == $past(sr_q, 2)) else $error("register not shown on outputs");
    AST_BLANK_LAG: assert property (@(posedge clk) disable iff (!resetn)
        s_blank_arrives |=> bl_q ##1 drive_out == `SLD_OUT_OFF) else $error("blank pin not followed");
    AST_UNBLANK_LAG: assert property (@(posedge clk) disable iff (!resetn)
        s_blank_leaves |=> !bl_q ##1 drive_out == $past(lat_q)) else $error("outputs not restored");
endmodule

// ==== tb/sld_host.sv ====
// Host controller model driving the serial pins
`timescale 1ns/1ns
module sld_host (
    input  wire logic clk,
    output logic      ser_in,
    output logic      shift_clk,
    output logic      load,
    output logic      blank
);
    // Idle pin levels
    initial begin
        ser_in = 1'b0;
        shift_clk = 1'b0;
        load = 1'b0;
        blank = 1'b0;
    end
    // One shift clock pulse, data settled well before the rise
    task automatic pulse(input logic b);
        @(negedge clk) ser_in = b;
        repeat (6) @(negedge clk);
        shift_clk = 1'b1;
        repeat (8) @(negedge clk);
        shift_clk = 1'b0;
        ser_in = ~b;
    endtask
    // Eight bits, most significant first, as a chained host would
    task automatic send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) pulse(v[i]);
    endtask
    // Set load and blank, then let them settle
    task automatic pins(input logic l, input logic b);
        @(negedge clk) load = l;
        blank = b;
        repeat (8) @(negedge clk);
    endtask
endmodule

// ==== tb/sld_driver_tb_top.sv ====
// Testbench for the serial-in latched driver
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; $display("unexpected %0t %h %h", $time, a, e); end end
module sld_driver_tb_top;
    logic               clk = 1'b0;
    logic               resetn = 1'b0;
    logic               word_ready = 1'b1;
    logic               ser_in, shift_clk, load, blank, cascade_out, word_valid;
    sld_pkg::sld_word_t drive_out, word_data;
    int                 miscompares = 0;
    int                 comparisons = 0;
    int                 n;
    // 20 MHz clock
    initial forever #25 clk = ~clk;
    sld_host host (.clk(clk), .ser_in(ser_in), .shift_clk(shift_clk), .load(load), .blank(blank));
    sld_driver uut (.clk(clk), .resetn(resetn), .ser_in(ser_in), .shift_clk(shift_clk), .load(load), .blank(blank),
                    .drive_out(drive_out), .cascade_out(cascade_out), .word_data(word_data),
                    .word_valid(word_valid), .word_ready(word_ready));
    // Counts and verdict
    task automatic wrap_up();
        $display("%0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Fill the word buffer past full while stalled, then drain it
    task automatic t_fifo();
        @(negedge clk) word_ready = 1'b0;
        for (int k = 0; k < 33; k++) host.send(k[7:0]);
        host.pins(1'b1, 1'b0);
        `CHK(drive_out, 8'h1f)
        host.pins(1'b0, 1'b0);
        n = 0;
        repeat (40) begin
            @(negedge clk);
            if (word_valid === 1'b1) begin
                `CHK(word_data, n[7:0])
                n++;
            end
            word_ready = 1'b1;
        end
        `CHK(n, 32)
        `CHK(word_valid, 1'b0)
        $display("t_fifo done");
    endtask
    // Shifting, cascade output and latch hold
    task automatic t_shift();
        host.send(8'ha5);
        `CHK(cascade_out, 1'b1)
        host.pins(1'b1, 1'b0);
        host.pins(1'b0, 1'b0);
        `CHK(drive_out, 8'ha5)
        host.send(8'h3c);
        `CHK(cascade_out, 1'b0)
        `CHK(drive_out, 8'ha5)
        $display("t_shift done");
    endtask
    // Blanking and transparent latches
    task automatic t_blank();
        host.pins(1'b0, 1'b1);
        `CHK(drive_out, 8'hff)
        host.pins(1'b0, 1'b0);
        `CHK(drive_out, 8'ha5)
        host.pins(1'b1, 1'b1);
        host.send(8'h81);
        `CHK(drive_out, 8'hff)
        host.pins(1'b1, 1'b0);
        `CHK(drive_out, 8'h81)
        host.pulse(1'b0);
        `CHK(drive_out, 8'h02)
        host.pins(1'b0, 1'b0);
        $display("t_blank done");
    endtask
    // Reset, then the tests in order
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        t_fifo();
        t_shift();
        t_blank();
        wrap_up();
    end
    // Watchdog of about 8000 cycles
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
endmodule
